/* rtl/rtsc_config.sv */
// Reference control, DAC power-down and touch-detect timing register bank with sequencers
`timescale 1ns/1ps
`default_nettype none
module rtsc_config #(
   parameter rtsc_pkg::rtsc_tab4_t SETTLE_CYC = rtsc_pkg::SETTLE_CYC_DFLT,
   parameter rtsc_pkg::rtsc_tab8_t PRE_CYC    = rtsc_pkg::PRE_CYC_DFLT,
   parameter rtsc_pkg::rtsc_tab8_t SNS_CYC    = rtsc_pkg::SNS_CYC_DFLT
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Register access port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [15:0] reg_wdata_i,
   output logic      [15:0] reg_rdata_o,
   output logic             reg_rvalid_o,
   // Converter handshake
   input  wire logic        conv_req_i,
   input  wire logic        conv_done_i,
   output logic             conv_start_o,
   // Reference and DAC controls
   output logic             ref_int_power_o,
   output logic             ref_int_sel_o,
   output logic             ref_volt_sel_o,
   output logic             dac_power_down_o,
   // Touch detect
   input  wire logic        touch_start_i,
   input  wire logic        touch_sense_i,
   output logic             precharge_o,
   output logic             sense_o,
   output logic             touch_done_o,
   output logic             touched_o
);

   typedef enum logic [1:0] {TD_IDLE, TD_PRE, TD_SNS} rtsc_td_state_t;

   // ---------------------------------------------------------------
   // Reset synchroniser
   // ---------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic       dac_pd_r;
   logic       ref_int_r;
   logic [1:0] ref_dly_r;
   logic       ref_pd_r;
   logic       ref_vsel_r;
   logic [2:0] pre_sel_r;
   logic [2:0] sns_sel_r;
   logic [2:0] sns_lat_r;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dac_pd_r <= rtsc_pkg::DAC_PD_RST;
      end else if (reg_wr_i && reg_addr_i == rtsc_pkg::ADDR_DAC_CTRL) begin
         dac_pd_r <= reg_wdata_i[rtsc_pkg::DAC_PD_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ref_int_r  <= rtsc_pkg::REF_INT_RST;
         ref_dly_r  <= rtsc_pkg::REF_DLY_RST;
         ref_pd_r   <= rtsc_pkg::REF_PD_RST;
         ref_vsel_r <= rtsc_pkg::REF_VSEL_RST;
      end else if (reg_wr_i && reg_addr_i == rtsc_pkg::ADDR_REF_CTRL) begin
         ref_int_r  <= reg_wdata_i[rtsc_pkg::REF_INT_BIT];
         ref_dly_r  <= reg_wdata_i[rtsc_pkg::REF_DLY_HI:rtsc_pkg::REF_DLY_LO];
         ref_pd_r   <= reg_wdata_i[rtsc_pkg::REF_PD_BIT];
         ref_vsel_r <= reg_wdata_i[rtsc_pkg::REF_VSEL_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pre_sel_r <= rtsc_pkg::PRE_RST;
         sns_sel_r <= rtsc_pkg::SNS_RST;
      end else if (reg_wr_i && reg_addr_i == rtsc_pkg::ADDR_TOUCH_TIMING) begin
         pre_sel_r <= reg_wdata_i[rtsc_pkg::PRE_HI:rtsc_pkg::PRE_LO];
         sns_sel_r <= reg_wdata_i[rtsc_pkg::SNS_HI:rtsc_pkg::SNS_LO];
      end
   end

   // ---------------------------------------------------------------
   // Read-back
   // ---------------------------------------------------------------
   function automatic logic [15:0] read_word(input logic [7:0] addr);
      logic [15:0] w;
      w = 16'h0000;
      case (addr)
         rtsc_pkg::ADDR_DAC_CTRL: begin
            w[rtsc_pkg::DAC_PD_BIT] = dac_pd_r;
         end
         rtsc_pkg::ADDR_REF_CTRL: begin
            w[rtsc_pkg::REF_INT_BIT]                      = ref_int_r;
            w[rtsc_pkg::REF_DLY_HI:rtsc_pkg::REF_DLY_LO]  = ref_dly_r;
            w[rtsc_pkg::REF_PD_BIT]                       = ref_pd_r;
            w[rtsc_pkg::REF_VSEL_BIT]                     = ref_vsel_r;
         end
         rtsc_pkg::ADDR_TOUCH_TIMING: begin
            w[rtsc_pkg::PRE_HI:rtsc_pkg::PRE_LO] = pre_sel_r;
            w[rtsc_pkg::SNS_HI:rtsc_pkg::SNS_LO] = sns_sel_r;
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      return w;
   endfunction

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o  <= 16'h0000;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= read_word(reg_addr_i);
         end
      end
   end

   // ---------------------------------------------------------------
   // Control outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dac_power_down_o <= rtsc_pkg::DAC_PD_RST;
         ref_int_sel_o    <= rtsc_pkg::REF_INT_RST;
         ref_volt_sel_o   <= rtsc_pkg::REF_VSEL_RST;
      end else begin
         dac_power_down_o <= dac_pd_r;
         ref_int_sel_o    <= ref_int_r;
         ref_volt_sel_o   <= ref_vsel_r;
      end
   end

   // ---------------------------------------------------------------
   // Reference sequencer
   // ---------------------------------------------------------------
   rtsc_pkg::rtsc_cnt_t settle_cyc_c;

   assign settle_cyc_c = rtsc_pkg::rtsc_cnt_t'(SETTLE_CYC[ref_dly_r]);

   rtsc_ref_power u_ref_power (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n),
      .int_sel_i    (ref_int_r),
      .auto_pd_i    (ref_pd_r),
      .settle_cyc_i (settle_cyc_c),
      .conv_req_i   (conv_req_i),
      .conv_done_i  (conv_done_i),
      .conv_start_o (conv_start_o),
      .ref_power_o  (ref_int_power_o)
   );

   // ---------------------------------------------------------------
   // Touch-detect sequencer
   // ---------------------------------------------------------------
   rtsc_td_state_t      td_state_r;
   logic                td_load_c;
   rtsc_pkg::rtsc_cnt_t td_count_c;
   logic                td_done;

   always_comb begin
      td_load_c  = 1'b0;
      td_count_c = '0;
      case (td_state_r)
         TD_IDLE: begin
            td_load_c  = touch_start_i;
            td_count_c = rtsc_pkg::rtsc_cnt_t'(PRE_CYC[pre_sel_r]);
         end
         TD_PRE: begin
            td_load_c  = td_done;
            td_count_c = rtsc_pkg::rtsc_cnt_t'(SNS_CYC[sns_lat_r]);
         end
         default: begin
            td_load_c  = 1'b0;
         end
      endcase
   end

   rtsc_delay_timer u_touch_timer (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .load_i  (td_load_c),
      .count_i (td_count_c),
      .busy_o  (),
      .done_o  (td_done)
   );

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         td_state_r   <= TD_IDLE;
         sns_lat_r    <= rtsc_pkg::SNS_RST;
         precharge_o  <= 1'b0;
         sense_o      <= 1'b0;
         touch_done_o <= 1'b0;
         touched_o    <= 1'b0;
      end else begin
         touch_done_o <= 1'b0;
         case (td_state_r)
            TD_IDLE: begin
               if (touch_start_i) begin
                  sns_lat_r   <= sns_sel_r;
                  precharge_o <= 1'b1;
                  td_state_r  <= TD_PRE;
               end
            end
            TD_PRE: begin
               if (td_done) begin
                  precharge_o <= 1'b0;
                  sense_o     <= 1'b1;
                  td_state_r  <= TD_SNS;
               end
            end
            TD_SNS: begin
               if (td_done) begin
                  sense_o      <= 1'b0;
                  touch_done_o <= 1'b1;
                  touched_o    <= touch_sense_i;
                  td_state_r   <= TD_IDLE;
               end
            end
            default: begin
               td_state_r <= TD_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_dac_pd_write: assert property (@(posedge clk_i) disable iff (!rst_n)
      (reg_wr_i && reg_addr_i == rtsc_pkg::ADDR_DAC_CTRL)
      |=> ##1 (dac_power_down_o == $past(reg_wdata_i[rtsc_pkg::DAC_PD_BIT], 2)))
      else $error("DAC power-down output does not follow write");

   a_int_sel_write: assert property (@(posedge clk_i) disable iff (!rst_n)
      (reg_wr_i && reg_addr_i == rtsc_pkg::ADDR_REF_CTRL)
      |=> ##1 (ref_int_sel_o == $past(reg_wdata_i[rtsc_pkg::REF_INT_BIT], 2)))
      else $error("reference select output does not follow write");

   a_vsel_write: assert property (@(posedge clk_i) disable iff (!rst_n)
      (reg_wr_i && reg_addr_i == rtsc_pkg::ADDR_REF_CTRL)
      |=> ##1 (ref_volt_sel_o == $past(reg_wdata_i[rtsc_pkg::REF_VSEL_BIT], 2)))
      else $error("reference voltage output does not follow write");

   a_ref_readback: assert property (@(posedge clk_i) disable iff (!rst_n)
      (reg_wr_i && reg_addr_i == rtsc_pkg::ADDR_REF_CTRL) ##1
      (reg_rd_i && !reg_wr_i && reg_addr_i == rtsc_pkg::ADDR_REF_CTRL)
      |=> (reg_rdata_o == {11'h000, $past(reg_wdata_i[4:0], 2)} && reg_rvalid_o))
      else $error("reference register read-back differs from write");

   a_settle_decode: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ref_dly_r == 2'h0) |-> (settle_cyc_c == '0))
      else $error("zero settle code gives nonzero delay");

   a_pre_before_sns: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(sense_o) |-> $past(precharge_o) && !precharge_o)
      else $error("sense phase not preceded by precharge");

   a_pre_start: assert property (@(posedge clk_i) disable iff (!rst_n)
      (td_state_r == TD_IDLE && touch_start_i) |=> (precharge_o && !sense_o) [*2])
      else $error("precharge did not start on request");

   a_pre_length: assert property (@(posedge clk_i) disable iff (!rst_n)
      (td_state_r == TD_IDLE && touch_start_i && pre_sel_r == 3'h0)
      |=> precharge_o [*8])
      else $error("shortest precharge ended too early");

   a_sns_done: assert property (@(posedge clk_i) disable iff (!rst_n)
      $fell(sense_o) |-> touch_done_o ##1 !touch_done_o)
      else $error("sense end without single done pulse");

endmodule // rtsc_config
`default_nettype wire

/* rtl/rtsc_pkg.sv */
// Constants, types and timing tables for the reference and touch-sense configuration block
package rtsc_pkg;

   // ---------------------------------------------------------------
   // Clock
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 20;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef logic [17:0] rtsc_cnt_t;
   typedef int unsigned rtsc_tab4_t [4];
   typedef int unsigned rtsc_tab8_t [8];

   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_DAC_CTRL     = 8'h02;
   localparam logic [7:0] ADDR_REF_CTRL     = 8'h03;
   localparam logic [7:0] ADDR_TOUCH_TIMING = 8'h05;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned DAC_PD_BIT   = 15;
   localparam int unsigned REF_INT_BIT  = 4;
   localparam int unsigned REF_DLY_HI   = 3;
   localparam int unsigned REF_DLY_LO   = 2;
   localparam int unsigned REF_PD_BIT   = 1;
   localparam int unsigned REF_VSEL_BIT = 0;
   localparam int unsigned PRE_HI       = 5;
   localparam int unsigned PRE_LO       = 3;
   localparam int unsigned SNS_HI       = 2;
   localparam int unsigned SNS_LO       = 0;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic       DAC_PD_RST   = 1'b1;
   localparam logic       REF_INT_RST  = 1'b0;
   localparam logic [1:0] REF_DLY_RST  = 2'h0;
   localparam logic       REF_PD_RST   = 1'b1;
   localparam logic       REF_VSEL_RST = 1'b0;
   localparam logic [2:0] PRE_RST      = 3'h0;
   localparam logic [2:0] SNS_RST      = 3'h0;

   // ---------------------------------------------------------------
   // Times in microseconds
   // ---------------------------------------------------------------
   localparam rtsc_tab4_t SETTLE_TIME_US = '{0, 100, 500, 1000};
   localparam rtsc_tab8_t PRE_TIME_US    = '{20, 84, 276, 340, 1044, 1108, 1300, 1364};
   localparam rtsc_tab8_t SNS_TIME_US    = '{32, 96, 544, 608, 2080, 2144, 2592, 2656};

   // ---------------------------------------------------------------
   // Conversion to clock cycles, rounded up
   // ---------------------------------------------------------------
   function automatic int unsigned us_to_cyc(input int unsigned us);
      return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   function automatic rtsc_tab4_t cyc4(input rtsc_tab4_t us);
      rtsc_tab4_t r;
      for (int i = 0; i < 4; i++) begin
         r[i] = us_to_cyc(us[i]);
      end
      return r;
   endfunction

   function automatic rtsc_tab8_t cyc8(input rtsc_tab8_t us);
      rtsc_tab8_t r;
      for (int i = 0; i < 8; i++) begin
         r[i] = us_to_cyc(us[i]);
      end
      return r;
   endfunction

   localparam rtsc_tab4_t SETTLE_CYC_DFLT = cyc4(SETTLE_TIME_US);
   localparam rtsc_tab8_t PRE_CYC_DFLT    = cyc8(PRE_TIME_US);
   localparam rtsc_tab8_t SNS_CYC_DFLT    = cyc8(SNS_TIME_US);

endpackage

/* rtl/rtsc_delay_timer.sv */
// Down-counting delay timer with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module rtsc_delay_timer (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Control
   input  wire logic              load_i,
   input  wire rtsc_pkg::rtsc_cnt_t count_i,
   // Status
   output logic                   busy_o,
   output logic                   done_o
);

   rtsc_pkg::rtsc_cnt_t cnt_r;

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r  <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (load_i) begin
         cnt_r  <= count_i;
         busy_o <= (count_i != '0);
         done_o <= (count_i == '0);
      end else begin
         done_o <= (cnt_r == rtsc_pkg::rtsc_cnt_t'(1));
         busy_o <= (cnt_r > rtsc_pkg::rtsc_cnt_t'(1));
         if (cnt_r != '0) begin
            cnt_r <= cnt_r - rtsc_pkg::rtsc_cnt_t'(1);
         end
      end
   end

   a_timer_expiry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cnt_r == rtsc_pkg::rtsc_cnt_t'(1) && !load_i) |=> done_o)
      else $error("timer did not expire after last count");

   a_timer_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cnt_r != '0 && !load_i) |=> (cnt_r == $past(cnt_r) - rtsc_pkg::rtsc_cnt_t'(1)))
      else $error("timer did not count down by one");

endmodule // rtsc_delay_timer
`default_nettype wire

/* rtl/rtsc_ref_power.sv */
// Internal reference power sequencer with settling hold-off
`timescale 1ns/1ps
`default_nettype none
module rtsc_ref_power (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Configuration
   input  wire logic              int_sel_i,
   input  wire logic              auto_pd_i,
   input  wire rtsc_pkg::rtsc_cnt_t settle_cyc_i,
   // Converter handshake and reference power output
   input  wire logic              conv_req_i,
   input  wire logic              conv_done_i,
   output logic                   conv_start_o,
   output logic                   ref_power_o
);

   typedef enum logic [1:0] {RP_IDLE, RP_SETTLE, RP_CONV} rtsc_rp_state_t;

   rtsc_rp_state_t state_r;
   logic           pend_r;
   logic           settled_r;
   logic           start_c;
   logic           load_c;
   logic           tmr_done;

   // ---------------------------------------------------------------
   // Start and power-up decisions
   // ---------------------------------------------------------------
   always_comb begin
      start_c = 1'b0;
      load_c  = 1'b0;
      case (state_r)
         RP_IDLE: begin
            if (pend_r && (!int_sel_i || (ref_power_o && settled_r))) begin
               start_c = 1'b1;
            end
            load_c = int_sel_i && !ref_power_o && (pend_r || !auto_pd_i);
         end
         RP_SETTLE: begin
            start_c = int_sel_i && tmr_done && pend_r;
         end
         default: begin
            start_c = 1'b0;
         end
      endcase
   end

   rtsc_delay_timer u_settle_timer (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .load_i  (load_c),
      .count_i (settle_cyc_i),
      .busy_o  (),
      .done_o  (tmr_done)
   );

   // ---------------------------------------------------------------
   // Pending request, new request wins over consumption
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_r <= 1'b0;
      end else if (conv_req_i) begin
         pend_r <= 1'b1;
      end else if (start_c) begin
         pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_start_o <= 1'b0;
      end else begin
         conv_start_o <= start_c;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r     <= RP_IDLE;
         ref_power_o <= 1'b0;
         settled_r   <= 1'b0;
      end else if (!int_sel_i && state_r != RP_CONV) begin
         ref_power_o <= 1'b0;
         settled_r   <= 1'b0;
         state_r     <= start_c ? RP_CONV : RP_IDLE;
      end else begin
         case (state_r)
            RP_IDLE: begin
               if (start_c) begin
                  state_r <= RP_CONV;
               end else if (load_c) begin
                  ref_power_o <= 1'b1;
                  settled_r   <= 1'b0;
                  state_r     <= RP_SETTLE;
               end else if (auto_pd_i && ref_power_o) begin
                  ref_power_o <= 1'b0;
                  settled_r   <= 1'b0;
               end
            end
            RP_SETTLE: begin
               if (tmr_done) begin
                  settled_r <= 1'b1;
                  state_r   <= start_c ? RP_CONV : RP_IDLE;
               end
            end
            RP_CONV: begin
               if (!int_sel_i) begin
                  ref_power_o <= 1'b0;
                  settled_r   <= 1'b0;
               end
               if (conv_done_i) begin
                  if (int_sel_i && auto_pd_i) begin
                     ref_power_o <= 1'b0;
                     settled_r   <= 1'b0;
                  end
                  state_r <= RP_IDLE;
               end
            end
            default: begin
               state_r <= RP_IDLE;
            end
         endcase
      end
   end

   a_ext_ref_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !int_sel_i |=> !ref_power_o)
      else $error("internal reference powered with external reference selected");

   a_start_settled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (conv_start_o && $past(int_sel_i)) |-> (settled_r && ref_power_o))
      else $error("conversion started on unsettled reference");

   a_conv_pwr_down: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_r == RP_CONV && conv_done_i && int_sel_i && auto_pd_i) |=> !ref_power_o ##1 !ref_power_o)
      else $error("reference not powered down after conversion");

   a_always_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ref_power_o && int_sel_i && !auto_pd_i) |=> ref_power_o)
      else $error("always-on reference dropped");

endmodule // rtsc_ref_power
`default_nettype wire

/* testbench/rtsc_conv_model.sv */
// Converter model answering each start pulse with a done pulse after a set latency
`timescale 1ns/1ps
`default_nettype none
module rtsc_conv_model (
   // Clock
   input  wire logic       clk_i,
   // Handshake
   input  wire logic [3:0] lat_i,
   input  wire logic       start_i,
   output logic            done_o
);
   logic [4:0] cnt_r = 5'h00;
   initial done_o = 1'b0;
   always @(posedge clk_i) begin
      done_o <= (cnt_r == 5'h01);
      if (start_i) begin
         cnt_r <= {1'b0, lat_i} + 5'h01;
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end
   end
endmodule // rtsc_conv_model
`default_nettype wire

/* testbench/reference_and_touch_sense_config_test.sv */
// Register, reference sequencing and touch timing tests
`timescale 1ns/1ps
`default_nettype none
module reference_and_touch_sense_config_test;
   localparam rtsc_pkg::rtsc_tab4_t ST = '{0, 5, 10, 20};
   localparam rtsc_pkg::rtsc_tab8_t PT = '{10, 12, 14, 16, 18, 20, 22, 24};
   localparam rtsc_pkg::rtsc_tab8_t NT = '{8, 11, 13, 15, 17, 19, 21, 23};
   logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, creq = 1'b0, tst = 1'b0, tsn = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wd = 16'h0000;
   logic [3:0]  lat = 4'h2;
   logic [15:0] rdata;
   logic        rv, cst, cdone, rpw, rsel, rvs, dac_power_down, pre, sns, tdn, tch;
   int          miscompares = 0, tests_run = 0, n, m, k;
   always #10 clk = ~clk;
   rtsc_config #(.SETTLE_CYC(ST), .PRE_CYC(PT), .SNS_CYC(NT)) i_rtsc_config (
      .clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .conv_req_i(creq),
      .conv_done_i(cdone), .conv_start_o(cst), .ref_int_power_o(rpw), .ref_int_sel_o(rsel),
      .ref_volt_sel_o(rvs), .dac_power_down_o(dac_power_down), .touch_start_i(tst), .touch_sense_i(tsn),
      .precharge_o(pre), .sense_o(sns), .touch_done_o(tdn), .touched_o(tch));
   rtsc_conv_model i_rtsc_conv_model (.clk_i(clk), .lat_i(lat), .start_i(cst), .done_o(cdone));
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk); addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1;
      chk(rv === 1'b1 && rdata === e, "read data");
   endtask
   task automatic conv(input int lo, input int hi);
      @(posedge clk); creq <= 1'b1;
      @(posedge clk); creq <= 1'b0;
      #1;
      n = 0;
      while (cst !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n >= lo && n <= hi, "start delay");
   endtask
   task automatic touch(input int p, input int s, input logic t);
      wreg(8'h05, 16'(p * 8 + s));
      @(posedge clk); tst <= 1'b1; tsn <= t;
      @(posedge clk); tst <= 1'b0;
      #1;
      m = int'(pre === 1'b1);
      k = 0;
      fork
         wreg(8'h05, 16'h003F);
         repeat (200) begin
            @(posedge clk);
            #1;
            m += int'(pre === 1'b1);
            k += int'(sns === 1'b1);
            if (tdn === 1'b1) break;
         end
      join
      chk(m == PT[p] + 1, "precharge length");
      chk(k == NT[s] + 1, "sense length");
      chk(tdn === 1'b1 && tch === t, "touch result");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rreg(8'h02, 16'h8000);
      rreg(8'h03, 16'h0002);
      rreg(8'h05, 16'h0000);
      rreg(8'h07, 16'h0000);
      chk(dac_power_down === 1'b1 && rpw === 1'b0, "reset outputs");
      wreg(8'h02, 16'h0000);
      chk(dac_power_down === 1'b0, "dac on");
      wreg(8'h03, 16'hFFFF);
      rreg(8'h03, 16'h001F);
      @(posedge clk); addr <= 8'h03; wd <= 16'hFFF3; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1;
      chk(rv === 1'b1 && rdata === 16'h0013, "write then read");
      chk(rsel === 1'b1 && rvs === 1'b1, "internal 2.5 V");
      wreg(8'h03, 16'h0000);
      chk(rsel === 1'b0 && rvs === 1'b0 && rpw === 1'b0, "external ref");
      conv(1, 1);
      chk(rpw === 1'b0, "internal ref stays off");
      for (int i = 0; i < 4; i++) begin
         lat <= 4'(i * 4);
         wreg(8'h03, 16'(18 + i * 4));
         conv(ST[i] + 2, ST[i] + 4);
         chk(rpw === 1'b1, "ref on in conversion");
         repeat (20) @(posedge clk);
         #1;
         chk(rpw === 1'b0, "ref off after conversion");
      end
      wreg(8'h03, 16'h0014);
      repeat (10) @(posedge clk);
      #1;
      chk(rpw === 1'b1, "ref always on");
      conv(1, 1);
      for (int i = 0; i < 8; i++) touch(i, 7 - i, 1'(i));
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      complete_run();
   end
   task complete_run;
      $display("compared %0d, mismatched %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
endmodule // reference_and_touch_sense_config_test
`default_nettype wire
